// ==== psi_panel_ctrl.sv ====
// master panel self-test sequencer and front-panel indicator driver
// assumes pins are asynchronous to ref_clk; register port is same-clock
//
// The placing of the registers and the plain strobed port were chosen for this implementation.
`timescale 1ns/10ps
`include "psi_defines.svh"

// Operation
// - test commands units, memtest, brigade defect-fire-normal
// - test lamp flashes, steady pass, rapid fail (irregular on memfail)
// - responder reports completion, cycles until stopped
// - zone lamps normal; missed test latches defect
// - panel reset aborts; restarts if qualified
// - failure: rapid lamp, buzzer; memfail irregular on these and normal
// - switch off suspends brigade signalling only
// - 19 flashing external lamps plus mimics
// - index bulb: fire unsilenced, lamp test, trial
// - door closed blanks internal-only lamps
// - normal lamp flashes slowly only in normal state
// - normal steady lamp test, irregular, rapid nv
// - defect lamp flashes on any defect source
// - defect steady on lamptest/watchdog, rapid nv
// - fire lamp flashes on fire sources
// - fire lamp steady lamptest, rapid nv write
// - ancillary isolate lamp flashes when isolated
// - non-fire lamp flashes on non-fire zone alarm
// - entry needs switch plus isolate or link
// - entry blocked by reset, fire, defects, inhibits
module psi_panel_ctrl #(
  parameter int RAPID_CYC =
    `PSI_RAPID_HALF_MS * 1000000 / `PSI_CLK_NS,
  parameter int TEST_MAX_CYC =
    `PSI_TEST_MAX_S * (1000000000 / `PSI_CLK_NS)
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire psi_pkg::psi_pins_s pins,
  input wire logic [3:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdata,
  output psi_pkg::psi_lamps_s lamps
);

  // ----------------------------------------------------------------
  // pin synchroniser
  // ----------------------------------------------------------------
  psi_pkg::psi_pins_s meta_r;
  psi_pkg::psi_pins_s in_r;
  logic doneSeen_r;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      meta_r <= '0;
      in_r <= '0;
      doneSeen_r <= 1'b0;
    end else begin
      meta_r <= pins;
      in_r <= meta_r;
      doneSeen_r <= in_r.respDone;
    end
  end

  // completion is a level toggle-free pulse; edge seen after sync
  wire logic respDoneEv = in_r.respDone & ~doneSeen_r;

  // ----------------------------------------------------------------
  // flash generator
  // ----------------------------------------------------------------
  logic [31:0] divCnt_r;
  logic [2:0] phase_r;
  logic rapidTick;

  assign rapidTick = (divCnt_r == 32'(RAPID_CYC - 1));

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      divCnt_r <= '0;
      phase_r <= '0;
    end else if (rapidTick) begin
      divCnt_r <= '0;
      phase_r <= phase_r + 3'h1;
    end else begin
      divCnt_r <= divCnt_r + 32'h1;
    end
  end

  // rapid toggles each tick, slow every four ticks
  wire logic fRapid = phase_r[0];
  wire logic fSlow = phase_r[2];
  logic [7:0] irregPat;
  assign irregPat = `PSI_IRREG_PAT;
  wire logic fIrreg = irregPat[phase_r];

  // ----------------------------------------------------------------
  // register port
  // ----------------------------------------------------------------
  logic memInject_r;
  logic [15:0] fireZone_r;
  psi_pkg::psi_test_e state_r;
  logic memBad_r;
  logic memDone_r;
  logic [7:0] passCnt_r;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      memInject_r <= `PSI_CTRL_RST;
      fireZone_r <= `PSI_ZTYPE_RST;
    end else if (regWr && regAddr == `PSI_ADDR_CTRL) begin
      memInject_r <= regWdata[0];
    end else if (regWr && regAddr == `PSI_ADDR_ZTYPE) begin
      fireZone_r <= regWdata[15:0];
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      regRdata <= '0;
    end else if (regRd) begin
      unique case (regAddr)
        `PSI_ADDR_CTRL: regRdata <= {31'h0, memInject_r};
        `PSI_ADDR_ZTYPE: regRdata <= {16'h0, fireZone_r};
        `PSI_ADDR_STAT: regRdata <= {20'h0, passCnt_r, memDone_r,
                                     memBad_r, state_r};
        default: regRdata <= '0;
      endcase
    end else begin
      regRdata <= '0;
    end
  end

  // ----------------------------------------------------------------
  // self-test entry and state
  // ----------------------------------------------------------------
  logic qualify;
  logic blocked;
  logic anyFail;
  logic [31:0] tmo_r;

  assign qualify = in_r.selfTestSw & (in_r.brigIsolate |
    in_r.brigTestIso | in_r.localEnableLink);
  assign blocked = in_r.panelReset | in_r.fireState | in_r.circuitInd |
    in_r.chargerPend | in_r.autoTestFire;
  // responder and display failures arrive from the loop
  assign anyFail = memBad_r | in_r.respFail | in_r.rduFail;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_r <= psi_pkg::ST_IDLE;
    end else if (in_r.panelReset) begin
      state_r <= psi_pkg::ST_IDLE;
    end else begin
      unique case (state_r)
        psi_pkg::ST_IDLE:
          if (qualify && !blocked) state_r <= psi_pkg::ST_RUN;
        psi_pkg::ST_RUN:
          if (anyFail || tmo_r == 32'(TEST_MAX_CYC - 1)) begin
            state_r <= psi_pkg::ST_FAIL;
          end else if (memDone_r && passCnt_r != 8'h0) begin
            state_r <= psi_pkg::ST_PASS;
          end
        psi_pkg::ST_PASS:
          if (anyFail) state_r <= psi_pkg::ST_FAIL;
        psi_pkg::ST_FAIL: state_r <= psi_pkg::ST_FAIL;
      endcase
    end
  end

  wire logic inTest = (state_r != psi_pkg::ST_IDLE);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tmo_r <= '0;
    end else if (state_r == psi_pkg::ST_RUN) begin
      tmo_r <= tmo_r + 32'h1;
    end else begin
      tmo_r <= '0;
    end
  end

  // responder completions counted; cycling continues after pass
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      passCnt_r <= '0;
    end else if (!inTest) begin
      passCnt_r <= '0;
    end else if (respDoneEv && passCnt_r != 8'hff) begin
      passCnt_r <= passCnt_r + 8'h1;
    end
  end

  // ----------------------------------------------------------------
  // master memory test: fill then verify a scratch array
  // ----------------------------------------------------------------
  logic [7:0] mem [`PSI_ZONES];
  logic [3:0] memAddr_r;
  logic memVerify_r;

  always_ff @(posedge ref_clk) begin
    if (inTest && !memVerify_r && !memDone_r) begin
      mem[memAddr_r] <= `PSI_MEM_SEED ^ {4'h0, memAddr_r};
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      memAddr_r <= '0;
      memVerify_r <= 1'b0;
      memDone_r <= 1'b0;
      memBad_r <= 1'b0;
    end else if (!inTest) begin
      memAddr_r <= '0;
      memVerify_r <= 1'b0;
      memDone_r <= 1'b0;
      memBad_r <= 1'b0;
    end else if (!memDone_r) begin
      memAddr_r <= memAddr_r + 4'h1;
      if (memAddr_r == 4'hf) begin
        memVerify_r <= 1'b1;
        memDone_r <= memVerify_r;
      end
      if (memVerify_r && ((mem[memAddr_r] ^ {7'h0, memInject_r}) !=
          (`PSI_MEM_SEED ^ {4'h0, memAddr_r}))) begin
        memBad_r <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // brigade signalling sequence
  // ----------------------------------------------------------------
  psi_pkg::psi_brig_e brig_r;
  logic [4:0] brigCnt_r;
  // switch back to normal freezes the sequence only
  wire logic brigRun = inTest & in_r.selfTestSw;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      brig_r <= psi_pkg::BR_DEFECT;
      brigCnt_r <= '0;
    end else if (!inTest) begin
      brig_r <= psi_pkg::BR_DEFECT;
      brigCnt_r <= '0;
    end else if (brigRun && rapidTick) begin
      if (brigCnt_r == `PSI_BRIG_STEP_TICKS - 5'h1) begin
        brigCnt_r <= '0;
        unique case (brig_r)
          psi_pkg::BR_DEFECT: brig_r <= psi_pkg::BR_FIRE;
          psi_pkg::BR_FIRE: brig_r <= psi_pkg::BR_NORMAL;
          psi_pkg::BR_NORMAL: brig_r <= psi_pkg::BR_DEFECT;
          default: brig_r <= psi_pkg::BR_DEFECT;
        endcase
      end else begin
        brigCnt_r <= brigCnt_r + 5'h1;
      end
    end
  end

  wire logic stDefect = brigRun & (brig_r == psi_pkg::BR_DEFECT);
  wire logic stFire = brigRun & (brig_r == psi_pkg::BR_FIRE);

  // ----------------------------------------------------------------
  // zone defect latch for missed test stimuli
  // ----------------------------------------------------------------
  logic [15:0] missLatch_r;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      missLatch_r <= '0;
    end else begin
      // set beats the reset clear
      missLatch_r <= (missLatch_r & {16{~in_r.panelReset}}) |
        (in_r.testMiss & {16{inTest}});
    end
  end

  // ----------------------------------------------------------------
  // indicator patterns
  // ----------------------------------------------------------------
  logic isFail;
  logic memFailShow;
  logic normalDark;
  logic lt;
  logic door;
  psi_pkg::psi_lamps_s nxt;

  assign isFail = (state_r == psi_pkg::ST_FAIL);
  assign memFailShow = isFail & memBad_r;
  assign lt = in_r.lampTest;
  assign door = in_r.doorOpen;
  assign normalDark = in_r.defectAny | in_r.fireAny | in_r.fireState |
    in_r.brigIsolate | in_r.ancIsolate | in_r.silenceMaster |
    in_r.silenceRemote | in_r.brigTestIso | in_r.selfTestSw |
    in_r.trialEvac | ~in_r.buzzerCancelN | in_r.panelReset |
    in_r.testLink | inTest | in_r.watchdogStop |
    in_r.watchdogLatched | in_r.noResponders | in_r.foreignUnits |
    (|(in_r.zoneAlarm & fireZone_r));

  always_comb begin
    nxt = '0;
    // lamp test first; then memory fail (normal), watchdog (defect), nv write
    if (lt) nxt.normal = 1'b1;
    else if (memFailShow) nxt.normal = fIrreg;
    else if (in_r.nvWrite) nxt.normal = fRapid;
    else nxt.normal = ~normalDark & fSlow;
    if (lt || in_r.watchdogStop) nxt.commonDefect = 1'b1;
    else if (in_r.nvWrite) nxt.commonDefect = fRapid;
    else nxt.commonDefect = fSlow & (in_r.defectAny | isFail |
      stDefect | (|missLatch_r));
    if (lt) nxt.commonFire = 1'b1;
    else if (in_r.nvWrite) nxt.commonFire = fRapid;
    else nxt.commonFire = fSlow & (in_r.fireAny |
      |(in_r.zoneAlarm & fireZone_r) | stFire);
    // internal-only lamps blank with the door shut
    nxt.ancIsolateLamp = door & (lt | (in_r.ancIsolate & fSlow));
    nxt.nonFireAlarmLamp = door & (lt |
      (fSlow & |(in_r.zoneAlarm & ~fireZone_r)));
    if (lt) nxt.selfTestLamp = door;
    else if (state_r == psi_pkg::ST_RUN) nxt.selfTestLamp = door & fSlow;
    else if (state_r == psi_pkg::ST_PASS) nxt.selfTestLamp = door;
    else nxt.selfTestLamp = door & isFail &
      (memFailShow ? fIrreg : fRapid);
    nxt.buzzer = isFail & (memFailShow ? fIrreg : fRapid);
    nxt.indexBulb = lt | in_r.trialEvac | (in_r.fireState &
      ~(in_r.silenceMaster | in_r.silenceRemote));
    nxt.brigDefect = stDefect;
    nxt.brigFire = stFire;
    nxt.testCmd = inTest;
    nxt.zoneAlarm = lt ? 16'hffff : (in_r.zoneAlarm & {16{fSlow}});
    nxt.zoneDefect = {16{door}} & (lt ? 16'hffff :
      ((in_r.zoneDefect | missLatch_r) & {16{fSlow}}));
    nxt.mimic = {nxt.normal, nxt.commonDefect, nxt.commonFire,
      nxt.zoneAlarm};
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) lamps <= '0;
    else lamps <= nxt;
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  chk_entry_gate: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(inTest) |-> $past(qualify) && !$past(blocked))
    else $error("self-test entered while not qualified");
  chk_reset_abort: assert property (@(posedge ref_clk) disable iff (rst)
    in_r.panelReset |=> state_r == psi_pkg::ST_IDLE)
    else $error("panel reset did not abort self-test");
  chk_brig_order: assert property (@(posedge ref_clk) disable iff (rst)
    inTest && brig_r == psi_pkg::BR_FIRE && $changed(brig_r)
    |-> $past(brig_r) == psi_pkg::BR_DEFECT)
    else $error("brigade fire not after defect");
  chk_brig_hold: assert property (@(posedge ref_clk) disable iff (rst)
    inTest && !in_r.selfTestSw && $past(inTest) |=> $stable(brig_r))
    else $error("brigade sequence moved while suspended");
  chk_fail_buzz: assert property (@(posedge ref_clk) disable iff (rst)
    isFail && !memBad_r && fRapid |=> lamps.buzzer)
    else $error("buzzer silent after failure");
  chk_lamp_test: assert property (@(posedge ref_clk) disable iff (rst)
    lt && !in_r.watchdogStop |=> lamps.normal && lamps.commonFire
    && lamps.indexBulb && lamps.zoneAlarm == 16'hffff)
    else $error("lamp test not steady");
  chk_door_blank: assert property (@(posedge ref_clk) disable iff (rst)
    !door |=> !lamps.ancIsolateLamp && !lamps.selfTestLamp
    && lamps.zoneDefect == 16'h0)
    else $error("internal lamp lit with door closed");
  chk_normal_dark: assert property (@(posedge ref_clk) disable iff (rst)
    normalDark && !lt && !in_r.nvWrite && !memFailShow
    |=> !lamps.normal)
    else $error("normal lamp lit off normal state");
  chk_bulb_silence: assert property (@(posedge ref_clk) disable iff (rst)
    (in_r.silenceMaster || in_r.silenceRemote) && !lt && !in_r.trialEvac
    |=> !lamps.indexBulb)
    else $error("index bulb lit while silenced");
  chk_miss_latch: assert property (@(posedge ref_clk) disable iff (rst)
    inTest && in_r.testMiss[2] |=> missLatch_r[2] [*2] or
    in_r.panelReset)
    else $error("missed test stimulus not latched");
  chk_pass_steady: assert property (@(posedge ref_clk) disable iff (rst)
    state_r == psi_pkg::ST_PASS && door && !lt |=> lamps.selfTestLamp
    || state_r != psi_pkg::ST_PASS)
    else $error("pass not shown steady");
  chk_timeout: assert property (@(posedge ref_clk) disable iff (rst)
    tmo_r == 32'(TEST_MAX_CYC - 1) && state_r == psi_pkg::ST_RUN
    && !in_r.panelReset |=> isFail)
    else $error("test ran past its time limit");

endmodule

// ==== psi_defines.svh ====
// constants of the panel self-test and indicator block
// assumes a 25 MHz system clock
`ifndef PSI_DEFINES_SVH
`define PSI_DEFINES_SVH
`define PSI_CLK_NS 40
`define PSI_RAPID_HALF_MS 125
`define PSI_TEST_MAX_S 60
`define PSI_BRIG_STEP_TICKS 5'h10
`define PSI_IRREG_PAT 8'hb2
`define PSI_ADDR_CTRL 4'h0
`define PSI_ADDR_ZTYPE 4'h4
`define PSI_ADDR_STAT 4'h8
`define PSI_CTRL_RST 1'h0
`define PSI_ZTYPE_RST 16'hffff
`define PSI_MEM_SEED 8'h5a
`define PSI_ZONES 16
`endif

// ==== psi_pkg.sv ====
// types of the panel self-test and indicator block
// assumes psi_defines.svh is on the include path
package psi_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_PASS, ST_FAIL} psi_test_e;
  typedef enum logic [1:0] {BR_DEFECT, BR_FIRE, BR_NORMAL} psi_brig_e;
  typedef struct packed {
    logic selfTestSw;
    logic brigIsolate;
    logic brigTestIso;
    logic localEnableLink;
    logic panelReset;
    logic fireState;
    logic circuitInd;
    logic chargerPend;
    logic autoTestFire;
    logic doorOpen;
    logic lampTest;
    logic trialEvac;
    logic silenceMaster;
    logic silenceRemote;
    logic ancIsolate;
    logic watchdogStop;
    logic watchdogLatched;
    logic nvWrite;
    logic noResponders;
    logic foreignUnits;
    logic testLink;
    logic buzzerCancelN;
    logic defectAny;
    logic fireAny;
    logic respDone;
    logic respFail;
    logic rduFail;
    logic [15:0] zoneAlarm;
    logic [15:0] zoneDefect;
    logic [15:0] testMiss;
  } psi_pins_s;
  typedef struct packed {
    logic normal;
    logic commonDefect;
    logic commonFire;
    logic ancIsolateLamp;
    logic nonFireAlarmLamp;
    logic selfTestLamp;
    logic indexBulb;
    logic buzzer;
    logic brigDefect;
    logic brigFire;
    logic testCmd;
    logic [15:0] zoneAlarm;
    logic [15:0] zoneDefect;
    logic [18:0] mimic;
  } psi_lamps_s;
endpackage

// ==== psi_loop_model.sv ====
// loop responders and remote display units facing the panel block
// assumes testCmd is a level from the panel, on ref_clk
`timescale 1ns/10ps
module psi_loop_model #(
  parameter int STEP_CYC = 30
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic testCmd,
  input wire logic [2:0] failCirc,
  input wire logic rduBad,
  output logic respDone,
  output logic respFail,
  output logic rduFail,
  output logic [15:0] testMiss
);
  logic [1:0] circ;
  int cnt;
  // ------------------------------
  // responder circuit cycle
  // ------------------------------
  // one step per circuit covers test-defect, test-fire and return;
  // STEP_CYC stands in for the 3.5 s and 0.5 s limits
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst || !testCmd) begin
      circ <= 2'h0;
      cnt <= 0;
      respDone <= 1'b0;
      respFail <= 1'b0;
      testMiss <= 16'h0;
    end else if (!respFail) begin
      cnt <= cnt + 1;
      respDone <= 1'b0;
      if (cnt == STEP_CYC - 1 && failCirc == {1'b1, circ}) begin
        // halted, stimulus stays on the failing circuit
        respFail <= 1'b1;
        testMiss[circ] <= 1'b1;
      end else if (cnt == STEP_CYC - 1) begin
        cnt <= 0;
        circ <= circ + 2'h1;
        // report after circuit 4, then start again at 1
        respDone <= (circ == 2'h3);
      end
    end
  end
  // ------------------------------
  // display unit memory test
  // ------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rduFail <= 1'b0;
    end else begin
      rduFail <= testCmd && rduBad;
    end
  end
endmodule

// ==== tb_psi_panel_ctrl.sv ====
// self-checking bench for the panel self-test and indicator block
// assumes psi_pkg and psi_loop_model are compiled before it
`timescale 1ns/10ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin \
  n_errors++; $display("[FAIL] %s exp %0h got %0h", n, e, g); end end
module tb_psi_panel_ctrl;
  localparam int NRM = 61;
  localparam int DEF = 60;
  localparam int FIR = 59;
  localparam int ANC = 58;
  localparam int NFA = 57;
  localparam int STL = 56;
  localparam int IDX = 55;
  localparam int BUZ = 54;
  localparam int TCM = 51;
  localparam logic [2:0] OFF = 3'h0;
  localparam logic [2:0] ON = 3'h1;
  localparam logic [2:0] SLOW = 3'h2;
  localparam logic [2:0] RAPID = 3'h3;
  localparam logic [2:0] IRREG = 3'h4;
  logic ref_clk;
  logic rst;
  psi_pkg::psi_pins_s tp;
  psi_pkg::psi_pins_s pins;
  psi_pkg::psi_lamps_s lamps;
  logic [3:0] regAddr;
  logic [31:0] regWdata;
  logic regWr;
  logic regRd;
  logic [31:0] regRdata;
  logic [2:0] failCirc;
  logic rduBad;
  logic mDone;
  logic mFail;
  logic mRdu;
  logic [15:0] mMiss;
  logic [61:0] lv;
  logic [31:0] rd;
  logic [7:0] seqv;
  logic [1:0] prev;
  logic [2:0] cat;
  int n_errors;
  int compares;
  assign lv = lamps;
  always_comb begin
    pins = tp;
    pins.respDone = mDone;
    pins.respFail = mFail;
    pins.rduFail = mRdu;
    pins.testMiss = mMiss;
  end
  psi_panel_ctrl #(.RAPID_CYC(4), .TEST_MAX_CYC(2000)) u_dut (
    .ref_clk(ref_clk), .rst(rst), .pins(pins), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .lamps(lamps));
  psi_loop_model #(.STEP_CYC(30)) u_loop (
    .ref_clk(ref_clk), .rst(rst), .testCmd(lamps.testCmd),
    .failCirc(failCirc), .rduBad(rduBad), .respDone(mDone),
    .respFail(mFail), .rduFail(mRdu), .testMiss(mMiss));
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  // ------------------------------
  // bus and lamp tasks
  // ------------------------------
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge ref_clk);
    regWr <= 1'b0;
  endtask
  task automatic rdv(input logic [3:0] a);
    @(posedge ref_clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge ref_clk);
    regRd <= 1'b0;
    #1;
    rd = regRdata;
  endtask
  task automatic rdc(input logic [3:0] a, input logic [31:0] e,
                     input string n);
    rdv(a);
    `CHK(n, e, rd)
  endtask
  task automatic waitSt(input logic [1:0] s, input string n);
    int i;
    i = 0;
    do begin
      rdv(4'h8);
      i++;
    end while (rd[1:0] !== s && i < 300);
    `CHK(n, s, rd[1:0])
  endtask
  task automatic settle;
    repeat (6) @(posedge ref_clk);
    #1;
  endtask
  // classifies a lamp over 64 cycles by its toggle count
  task automatic lamp(input int b, input logic [2:0] e, input string n);
    int ones;
    int zeros;
    int tg;
    logic p;
    ones = 0;
    zeros = 0;
    tg = 0;
    p = lv[b];
    repeat (64) begin
      @(posedge ref_clk);
      #1;
      if (lv[b] === 1'b1) ones++;
      if (lv[b] === 1'b0) zeros++;
      if (lv[b] !== p) tg++;
      p = lv[b];
    end
    if (ones + zeros != 64) cat = 3'h5;
    else if (ones == 64) cat = ON;
    else if (zeros == 64) cat = OFF;
    else if (tg < 7) cat = SLOW;
    else if (tg < 14) cat = IRREG;
    else cat = RAPID;
    `CHK(n, e, cat)
  endtask
  task automatic end_of_test;
    $display("n_errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge ref_clk);
    n_errors++;
    end_of_test;
  end
  // ------------------------------
  // main sequence
  // ------------------------------
  initial begin
    tp = '0;
    tp.buzzerCancelN = 1'b1;
    tp.doorOpen = 1'b1;
    regAddr = 4'h0;
    regWdata = 32'h0;
    regWr = 1'b0;
    regRd = 1'b0;
    failCirc = 3'h0;
    rduBad = 1'b0;
    n_errors = 0;
    compares = 0;
    rst = 1'b1;
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    rdc(4'h0, 32'h0, "ctrl rst");
    rdc(4'h4, 32'hffff, "ztype rst");
    rdc(4'h8, 32'h0, "status rst");
    wr(4'h4, 32'h00ff);
    wr(4'h8, 32'h0fff);
    wr(4'hc, 32'h1);
    rdc(4'h4, 32'h00ff, "ztype wr");
    rdc(4'h8, 32'h0, "status ro");
    rdc(4'hc, 32'h0, "unmapped");
    settle;
    lamp(NRM, SLOW, "normal");
    lamp(18, SLOW, "mimic normal");
    @(posedge ref_clk) tp.zoneAlarm <= 16'h0100;
    settle;
    lamp(43, SLOW, "zone8");
    lamp(NFA, SLOW, "nonfire");
    lamp(FIR, OFF, "fire nf");
    @(posedge ref_clk) tp.doorOpen <= 1'b0;
    settle;
    lamp(NFA, OFF, "nf door");
    lamp(43, SLOW, "zone8 door");
    @(posedge ref_clk) tp.zoneAlarm <= 16'h0001;
    settle;
    lamp(FIR, SLOW, "fire zone");
    lamp(NRM, OFF, "normal fire");
    @(posedge ref_clk) tp.lampTest <= 1'b1;
    settle;
    lamp(NRM, ON, "lt normal");
    lamp(DEF, ON, "lt defect");
    lamp(FIR, ON, "lt fire");
    lamp(IDX, ON, "lt bulb");
    lamp(35, ON, "lt zone0");
    lamp(ANC, OFF, "lt anc door");
    @(posedge ref_clk) tp.doorOpen <= 1'b1;
    settle;
    lamp(ANC, ON, "lt anc");
    @(posedge ref_clk) tp.lampTest <= 1'b0;
    @(posedge ref_clk) tp.zoneAlarm <= 16'h0;
    @(posedge ref_clk) tp.fireState <= 1'b1;
    settle;
    lamp(IDX, ON, "bulb fire");
    @(posedge ref_clk) tp.silenceRemote <= 1'b1;
    settle;
    lamp(IDX, OFF, "bulb silenced");
    @(posedge ref_clk) tp.trialEvac <= 1'b1;
    settle;
    lamp(IDX, ON, "bulb trial");
    @(posedge ref_clk) begin
      tp.fireState <= 1'b0;
      tp.silenceRemote <= 1'b0;
      tp.trialEvac <= 1'b0;
      tp.ancIsolate <= 1'b1;
      tp.defectAny <= 1'b1;
    end
    settle;
    lamp(ANC, SLOW, "anc");
    lamp(DEF, SLOW, "defect");
    lamp(NRM, OFF, "normal defect");
    @(posedge ref_clk) tp.watchdogStop <= 1'b1;
    settle;
    lamp(DEF, ON, "defect wdog");
    @(posedge ref_clk) tp.watchdogStop <= 1'b0;
    @(posedge ref_clk) tp.nvWrite <= 1'b1;
    settle;
    lamp(DEF, RAPID, "defect nv");
    lamp(NRM, RAPID, "normal nv");
    lamp(FIR, RAPID, "fire nv");
    @(posedge ref_clk) tp.nvWrite <= 1'b0;
    @(posedge ref_clk) tp.defectAny <= 1'b0;
    @(posedge ref_clk) tp.ancIsolate <= 1'b0;
    @(posedge ref_clk) tp.selfTestSw <= 1'b1;
    settle;
    rdc(4'h8, 32'h0, "no qualifier");
    @(posedge ref_clk) tp.fireState <= 1'b1;
    @(posedge ref_clk) tp.brigIsolate <= 1'b1;
    settle;
    rdc(4'h8, 32'h0, "blocked");
    @(posedge ref_clk) tp.fireState <= 1'b0;
    waitSt(2'h1, "entry");
    `CHK("testCmd", 1'b1, lv[TCM])
    lamp(STL, SLOW, "st run");
    seqv = 8'h0;
    prev = 2'h3;
    repeat (240) begin
      @(posedge ref_clk);
      #1;
      if (lv[53:52] !== prev && seqv[7:6] === 2'h0) begin
        seqv = {seqv[5:0], lv[53:52]};
      end
      prev = lv[53:52];
    end
    // first step to fire lands inside the run-lamp window
    `CHK("brigade", 8'h49, seqv)
    waitSt(2'h2, "pass");
    `CHK("done count", 1'b1, rd[11:4] != 8'h0)
    lamp(STL, ON, "st pass");
    @(posedge ref_clk) tp.selfTestSw <= 1'b0;
    settle;
    lamp(53, OFF, "brig def off");
    lamp(52, OFF, "brig fire off");
    `CHK("testCmd held", 1'b1, lv[TCM])
    @(posedge ref_clk) tp.panelReset <= 1'b1;
    waitSt(2'h0, "reset exit");
    `CHK("testCmd exit", 1'b0, lv[TCM])
    @(posedge ref_clk) tp.selfTestSw <= 1'b1;
    settle;
    rdc(4'h8, 32'h0, "reset held");
    @(posedge ref_clk) tp.panelReset <= 1'b0;
    waitSt(2'h1, "restart");
    failCirc <= 3'h6;
    waitSt(2'h3, "resp fail");
    lamp(BUZ, RAPID, "buzzer");
    lamp(STL, RAPID, "st fail");
    lamp(21, SLOW, "zone2 defect");
    lamp(DEF, SLOW, "defect fail");
    failCirc <= 3'h0;
    settle;
    waitSt(2'h3, "fail sticky");
    @(posedge ref_clk) tp.selfTestSw <= 1'b0;
    @(posedge ref_clk) tp.panelReset <= 1'b1;
    settle;
    @(posedge ref_clk) tp.panelReset <= 1'b0;
    waitSt(2'h0, "fail cleared");
    lamp(21, OFF, "zone2 clear");
    wr(4'h0, 32'h1);
    rdc(4'h0, 32'h1, "ctrl wr");
    @(posedge ref_clk) tp.selfTestSw <= 1'b1;
    waitSt(2'h3, "mem fail");
    `CHK("memBad", 1'b1, rd[2])
    lamp(NRM, IRREG, "normal mem");
    lamp(BUZ, IRREG, "buzzer mem");
    @(posedge ref_clk) tp.selfTestSw <= 1'b0;
    @(posedge ref_clk) tp.panelReset <= 1'b1;
    wr(4'h0, 32'h0);
    rduBad <= 1'b1;
    settle;
    @(posedge ref_clk) tp.panelReset <= 1'b0;
    @(posedge ref_clk) tp.selfTestSw <= 1'b1;
    waitSt(2'h3, "rdu fail");
    `CHK("memBad rdu", 1'b0, rd[2])
    end_of_test;
  end
endmodule
